/* File: rdt_display_timing.sv */
/*
  Host register interface and raster timing generator: index register,
  eighteen data registers, sync and display-enable timing, refresh and
  row addresses, light pen capture.
  Assumes bus pins and the light pen strobe are asynchronous to clk_sys
  and that the bus enable strobe lasts several clk_sys periods.
*/
// Function
// - One index plus eighteen data registers
// - Eight-bit data bus with processor controls
// - Drive vertical sync, horizontal sync, display enable
// - Drive 14-bit refresh and 5-bit row addresses
// - Indices 0-2 horizontal timing, write only
// - Index 3 sync width, write only
// - Indices 4,6,7 vertical timing, write only
// - Index 5 vertical adjust scan lines
// - Index 9 scan lines per character row
// - Index 8 low bits pick interlace mode
// - Cursor start with blink control bits
// - Index 11 cursor end scan line
// - Cursor address pair readable and writable
// - Light pen pair read only
// - Synced strobe rise captures refresh address
// - Start address used at next frame
// - Write on enable fall, drive while high
`timescale 1ns/10ps
`default_nettype none

module rdt_display_timing (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Processor bus
  input wire logic chip_select_low,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic bus_enable,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_out_enable,
  // Light pen
  input wire logic light_pen_strobe,
  // Video timing
  output logic vertical_sync,
  output logic horizontal_sync,
  output logic display_window,
  output logic [13:0] refresh_memory_address,
  output logic [4:0] scan_row_count
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rdt_pkg::rdt_bus_type bus_s1;
    rdt_pkg::rdt_bus_type bus_s2;
    rdt_pkg::rdt_bus_type bus_s3;
    logic e_level;
    logic lp_s1;
    logic lp_s2;
    logic lp_s3;
    logic lp_level;
    logic [4:0] index;
    logic [17:0][7:0] regs;
    logic [7:0] dout;
    logic [7:0] hcnt;
    logic hsync_on;
    logic [3:0] hsw_cnt;
    rdt_pkg::rdt_vphase_type phase;
    logic [6:0] row;
    logic [4:0] scan;
    logic [4:0] adj_cnt;
    logic field;
    logic vsync_on;
    logic vs_wait;
    logic [3:0] vs_cnt;
    logic [13:0] line_addr;
    logic [13:0] ma_cnt;
    logic display;
  } rdt_state_type;

  rdt_state_type st;
  rdt_state_type next_st;
  rdt_pkg::rdt_bus_type bus_pins;

  assign bus_pins = '{cs_n: chip_select_low, rs: register_select, rnw: read_not_write,
                      e: bus_enable, data: data_in};

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  logic [7:0] h_total;
  logic [7:0] h_disp;
  logic [7:0] h_sync_pos;
  logic [3:0] h_sync_width;
  logic [6:0] v_total;
  logic [4:0] v_adjust;
  logic [6:0] v_disp;
  logic [6:0] v_sync_pos;
  logic interlace_on;
  logic interlace_video;
  logic [4:0] max_scan;
  logic [13:0] start_address;

  assign h_total = st.regs[rdt_pkg::IDX_HORIZONTAL_TOTAL];
  assign h_disp = st.regs[rdt_pkg::IDX_HORIZONTAL_DISPLAYED];
  assign h_sync_pos = st.regs[rdt_pkg::IDX_HORIZONTAL_SYNC_POSITION];
  assign h_sync_width = st.regs[rdt_pkg::IDX_SYNC_WIDTH][3:0];
  assign v_total = st.regs[rdt_pkg::IDX_VERTICAL_TOTAL][6:0];
  assign v_adjust = st.regs[rdt_pkg::IDX_VERTICAL_TOTAL_ADJUST][4:0];
  assign v_disp = st.regs[rdt_pkg::IDX_VERTICAL_DISPLAYED][6:0];
  assign v_sync_pos = st.regs[rdt_pkg::IDX_VERTICAL_SYNC_POSITION][6:0];
  assign interlace_on = st.regs[rdt_pkg::IDX_INTERLACE_MODE_SKEW][rdt_pkg::INTERLACE_LO_BIT];
  assign interlace_video = interlace_on
                         & st.regs[rdt_pkg::IDX_INTERLACE_MODE_SKEW][rdt_pkg::INTERLACE_HI_BIT];
  assign max_scan = st.regs[rdt_pkg::IDX_MAX_SCAN_LINE][4:0];
  assign start_address = {st.regs[rdt_pkg::IDX_START_ADDRESS_HIGH][5:0],
                          st.regs[rdt_pkg::IDX_START_ADDRESS_LOW]};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic e_fall;
  logic host_write;
  logic lp_rise;
  logic h_end;
  logic row_last;
  logic frame_start;
  logic row_advance;
  logic [4:0] scan_step;
  logic [4:0] scan_first;
  logic [3:0] hsw_next;
  logic [7:0] read_value;
  logic bus_steady;

  always_comb begin
    next_st = st;
    // --------------------------------------------------------------
    // Three-stage synchronisers for bus and strobe pins
    // --------------------------------------------------------------
    next_st.bus_s1 = bus_pins;
    next_st.bus_s2 = st.bus_s1;
    next_st.bus_s3 = st.bus_s2;
    next_st.lp_s1 = light_pen_strobe;
    next_st.lp_s2 = st.lp_s1;
    next_st.lp_s3 = st.lp_s2;
    if (st.bus_s2.e == st.bus_s3.e) begin
      next_st.e_level = st.bus_s3.e;
    end
    if (st.lp_s2 == st.lp_s3) begin
      next_st.lp_level = st.lp_s3;
    end
    // --------------------------------------------------------------
    // Strobe edges
    // --------------------------------------------------------------
    e_fall = st.e_level & ~st.bus_s2.e & ~st.bus_s3.e;
    lp_rise = ~st.lp_level & st.lp_s2 & st.lp_s3;
    bus_steady = (st.bus_s2 == st.bus_s3);
    host_write = e_fall & bus_steady & ~st.bus_s3.cs_n & ~st.bus_s3.rnw;

    // --------------------------------------------------------------
    // Host writes
    // --------------------------------------------------------------
    if (host_write && !st.bus_s3.rs) begin
      next_st.index = st.bus_s3.data[4:0];
    end
    if (host_write && st.bus_s3.rs) begin
      case (st.index)
        rdt_pkg::IDX_START_ADDRESS_HIGH,
        rdt_pkg::IDX_CURSOR_ADDRESS_HIGH: begin
          next_st.regs[st.index] = st.bus_s3.data & rdt_pkg::ADDR_HIGH_MASK;
        end
        rdt_pkg::IDX_HORIZONTAL_TOTAL, rdt_pkg::IDX_HORIZONTAL_DISPLAYED,
        rdt_pkg::IDX_HORIZONTAL_SYNC_POSITION, rdt_pkg::IDX_SYNC_WIDTH,
        rdt_pkg::IDX_VERTICAL_TOTAL, rdt_pkg::IDX_VERTICAL_TOTAL_ADJUST,
        rdt_pkg::IDX_VERTICAL_DISPLAYED, rdt_pkg::IDX_VERTICAL_SYNC_POSITION,
        rdt_pkg::IDX_INTERLACE_MODE_SKEW, rdt_pkg::IDX_MAX_SCAN_LINE,
        rdt_pkg::IDX_CURSOR_START_LINE, rdt_pkg::IDX_CURSOR_END_LINE,
        rdt_pkg::IDX_START_ADDRESS_LOW, rdt_pkg::IDX_CURSOR_ADDRESS_LOW: begin
          next_st.regs[st.index] = st.bus_s3.data;
        end
        default: begin
          next_st.regs = st.regs;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Read data, always held in a register
    // --------------------------------------------------------------
    case (st.index)
      rdt_pkg::IDX_CURSOR_ADDRESS_HIGH, rdt_pkg::IDX_CURSOR_ADDRESS_LOW,
      rdt_pkg::IDX_LIGHT_PEN_HIGH, rdt_pkg::IDX_LIGHT_PEN_LOW: begin
        read_value = st.regs[st.index];
      end
      default: begin
        read_value = rdt_pkg::READ_ZERO;
      end
    endcase
    next_st.dout = st.bus_s3.rs ? read_value : rdt_pkg::READ_ZERO;

    // --------------------------------------------------------------
    // Light pen capture of the current refresh address
    // --------------------------------------------------------------
    if (lp_rise) begin
      next_st.regs[rdt_pkg::IDX_LIGHT_PEN_HIGH] = {2'b00, st.ma_cnt[13:8]};
      next_st.regs[rdt_pkg::IDX_LIGHT_PEN_LOW] = st.ma_cnt[7:0];
    end

    // --------------------------------------------------------------
    // Horizontal counter and sync
    // --------------------------------------------------------------
    h_end = (st.hcnt == h_total);
    next_st.hcnt = h_end ? 8'h00 : st.hcnt + 8'h01;
    hsw_next = st.hsw_cnt + 4'h1;
    if (st.hcnt == h_sync_pos) begin
      next_st.hsync_on = 1'b1;
      next_st.hsw_cnt = 4'h0;
    end else if (st.hsync_on) begin
      next_st.hsw_cnt = hsw_next;
      if (hsw_next == h_sync_width) begin
        next_st.hsync_on = 1'b0;
      end
    end

    // --------------------------------------------------------------
    // Vertical sequencing
    // --------------------------------------------------------------
    scan_step = interlace_video ? rdt_pkg::SCAN_STEP_VIDEO : rdt_pkg::SCAN_STEP_NORMAL;
    row_last = interlace_video ? ((st.scan | 5'h01) >= max_scan) : (st.scan == max_scan);
    frame_start = 1'b0;
    row_advance = 1'b0;
    scan_first = 5'h00;
    if (h_end) begin
      case (st.phase)
        rdt_pkg::VP_ROWS: begin
          if (row_last) begin
            next_st.line_addr = st.line_addr + {6'h00, h_disp};
            if (st.row == v_total) begin
              if (v_adjust == 5'h00) begin
                frame_start = 1'b1;
              end else begin
                next_st.phase = rdt_pkg::VP_ADJUST;
                next_st.adj_cnt = 5'h00;
                next_st.scan = 5'h00;
              end
            end else begin
              next_st.row = st.row + 7'h01;
              row_advance = 1'b1;
            end
          end else begin
            next_st.scan = st.scan + scan_step;
          end
        end
        rdt_pkg::VP_ADJUST: begin
          next_st.scan = st.scan + rdt_pkg::SCAN_STEP_NORMAL;
          next_st.adj_cnt = st.adj_cnt + 5'h01;
          if (st.adj_cnt + 5'h01 == v_adjust) begin
            frame_start = 1'b1;
          end
        end
        default: begin
          frame_start = 1'b1;
        end
      endcase
      if (frame_start) begin
        next_st.phase = rdt_pkg::VP_ROWS;
        next_st.row = 7'h00;
        next_st.field = interlace_on ? ~st.field : 1'b0;
        next_st.line_addr = start_address;
        row_advance = 1'b1;
      end
      scan_first = (interlace_video && next_st.field) ? 5'h01 : 5'h00;
      if (row_advance) begin
        next_st.scan = scan_first;
      end
      next_st.ma_cnt = next_st.line_addr;
    end else begin
      next_st.ma_cnt = st.ma_cnt + 14'h0001;
    end

    // --------------------------------------------------------------
    // Vertical sync, sixteen scan lines; on even interlace fields it starts half a line late and is half a line shorter
    // --------------------------------------------------------------
    if (h_end && st.vsync_on) begin
      next_st.vs_cnt = st.vs_cnt + 4'h1;
      if (st.vs_cnt == rdt_pkg::VSYNC_LAST_LINE) begin
        next_st.vsync_on = 1'b0;
      end
    end
    if (st.vs_wait && st.hcnt == {1'b0, h_total[7:1]}) begin
      next_st.vs_wait = 1'b0;
      next_st.vsync_on = 1'b1;
      next_st.vs_cnt = 4'h0;
    end
    if (h_end && row_advance && next_st.row == v_sync_pos) begin
      if (interlace_on && !next_st.field) begin
        next_st.vs_wait = 1'b1;
      end else begin
        next_st.vsync_on = 1'b1;
        next_st.vs_cnt = 4'h0;
      end
    end

    // --------------------------------------------------------------
    // Display enable from next counter values
    // --------------------------------------------------------------
    next_st.display = (next_st.hcnt < h_disp) && (next_st.phase == rdt_pkg::VP_ROWS)
                    && (next_st.row < v_disp);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.index <= rdt_pkg::INDEX_RESET;
      st.regs <= {rdt_pkg::NUM_REGS{rdt_pkg::REG_RESET}};
      st.phase <= rdt_pkg::VP_ROWS;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out = st.dout;
  assign data_out_enable = st.e_level & ~st.bus_s3.cs_n & st.bus_s3.rnw;
  assign vertical_sync = st.vsync_on;
  assign horizontal_sync = st.hsync_on;
  assign display_window = st.display;
  assign refresh_memory_address = st.ma_cnt;
  assign scan_row_count = st.scan;

endmodule : rdt_display_timing

`default_nettype wire

/* File: rdt_pkg.sv */
/*
  Constants, field layouts and carrier types for the raster display
  timing register block.
  Assumes a single 250 MHz system clock and an asynchronous active-low reset.
*/
`default_nettype none

package rdt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned MA_W = 14;
  localparam int unsigned RA_W = 5;
  localparam int unsigned NUM_REGS = 18;

  // ----------------------------------------------------------------
  // Data register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_HORIZONTAL_TOTAL = 5'h00;
  localparam logic [4:0] IDX_HORIZONTAL_DISPLAYED = 5'h01;
  localparam logic [4:0] IDX_HORIZONTAL_SYNC_POSITION = 5'h02;
  localparam logic [4:0] IDX_SYNC_WIDTH = 5'h03;
  localparam logic [4:0] IDX_VERTICAL_TOTAL = 5'h04;
  localparam logic [4:0] IDX_VERTICAL_TOTAL_ADJUST = 5'h05;
  localparam logic [4:0] IDX_VERTICAL_DISPLAYED = 5'h06;
  localparam logic [4:0] IDX_VERTICAL_SYNC_POSITION = 5'h07;
  localparam logic [4:0] IDX_INTERLACE_MODE_SKEW = 5'h08;
  localparam logic [4:0] IDX_MAX_SCAN_LINE = 5'h09;
  localparam logic [4:0] IDX_CURSOR_START_LINE = 5'h0A;
  localparam logic [4:0] IDX_CURSOR_END_LINE = 5'h0B;
  localparam logic [4:0] IDX_START_ADDRESS_HIGH = 5'h0C;
  localparam logic [4:0] IDX_START_ADDRESS_LOW = 5'h0D;
  localparam logic [4:0] IDX_CURSOR_ADDRESS_HIGH = 5'h0E;
  localparam logic [4:0] IDX_CURSOR_ADDRESS_LOW = 5'h0F;
  localparam logic [4:0] IDX_LIGHT_PEN_HIGH = 5'h10;
  localparam logic [4:0] IDX_LIGHT_PEN_LOW = 5'h11;

  // ----------------------------------------------------------------
  // Reset values, field layouts and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] INDEX_RESET = 5'h00;
  localparam logic [7:0] ADDR_HIGH_MASK = 8'h3F;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int unsigned INTERLACE_LO_BIT = 0;
  localparam int unsigned INTERLACE_HI_BIT = 1;
  localparam int unsigned CURSOR_BLINK_BIT = 6;
  localparam int unsigned CURSOR_PERIOD_BIT = 5;
  localparam logic [3:0] VSYNC_LAST_LINE = 4'hF;
  localparam logic [4:0] SCAN_STEP_NORMAL = 5'h01;
  localparam logic [4:0] SCAN_STEP_VIDEO = 5'h02;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {VP_ROWS, VP_ADJUST} rdt_vphase_type;

  typedef struct packed {
    logic cs_n;
    logic rs;
    logic rnw;
    logic e;
    logic [7:0] data;
  } rdt_bus_type;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic display;
    logic [13:0] ma;
    logic [4:0] ra;
  } rdt_timing_type;

endpackage : rdt_pkg

`default_nettype wire

/* File: rdt_host_model.sv */
/* Host bus master model for the display timing block.
   Assumes clk_sys drives it and the device synchronises its pins. */
`timescale 1ns/10ps
`default_nettype none
module rdt_host_model (
  // Clock
  input wire logic clk_sys,
  // Bus toward the device
  output var rdt_pkg::rdt_bus_type bus,
  input wire logic [7:0] data_out,
  input wire logic data_out_enable
);
  initial begin
    bus = '{cs_n: 1'b1, rs: 1'b0, rnw: 1'b1, e: 1'b0, data: 8'hA5};
  end
  // ------
  // One bus cycle
  // ------
  task automatic access(input logic sel, input logic rs, input logic rnw, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk_sys);
    bus.cs_n = ~sel;
    bus.rs = rs;
    bus.rnw = rnw;
    bus.data = d;
    repeat (4) @(negedge clk_sys);
    bus.e = 1'b1;
    repeat (7) @(negedge clk_sys);
    q = data_out;
    @(negedge clk_sys);
    bus.e = 1'b0;
    repeat (6) @(negedge clk_sys);
    bus.cs_n = 1'b1;
    bus.data = ~d;
  endtask : access
endmodule : rdt_host_model
`default_nettype wire

/* File: rdt_display_timing_assertions.sv */
/* Checker for the bus side of the display timing block.
   Assumes the host holds its controls across each strobe. */
`timescale 1ns/10ps
`default_nettype none
module rdt_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Bus and pen
  input wire logic chip_select_low,
  input wire logic read_not_write,
  input wire logic bus_enable,
  input wire logic light_pen_strobe,
  input wire logic [7:0] data_out,
  input wire logic data_out_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ------
  // Read strobe phases
  // ------
  sequence rd_open;
    $rose(bus_enable) && !chip_select_low && read_not_write;
  endsequence
  sequence rd_close;
    $fell(bus_enable);
  endsequence
  oe_opens_a: assert property (rd_open |-> ##[2:5] data_out_enable) else $error("read drive late");
  oe_closes_a: assert property (rd_close |-> ##[2:5] !data_out_enable) else $error("read drive stuck");
  oe_cause_a: assert property ($rose(data_out_enable) |-> $past(bus_enable, 2) &&
    !$past(chip_select_low, 2) && $past(read_not_write, 2)) else $error("read drive without read");
  oe_holds_a: assert property ($rose(data_out_enable) |=> data_out_enable[*2]) else $error("read drive short");
  deselect_quiet_a: assert property (chip_select_low[*6] |-> !data_out_enable) else $error("drive unselected");
  write_quiet_a: assert property (!read_not_write[*6] |-> !data_out_enable) else $error("drive on write");
  idle_quiet_a: assert property (!bus_enable[*6] |-> !data_out_enable) else $error("drive without strobe");
  read_steady_a: assert property (data_out_enable[*3] ##1 (data_out_enable && !light_pen_strobe)
    |-> $stable(data_out)) else $error("read data moved");
endmodule : rdt_checker
bind rdt_display_timing rdt_checker u_checker (.clk_sys, .arst_n, .chip_select_low, .read_not_write,
  .bus_enable, .light_pen_strobe, .data_out, .data_out_enable);
`default_nettype wire

/* File: test_raster_display_timing_registers.sv */
/* Bench: register map walk, reset, index read, deselect, light pen.
   Assumes rdt_host_model as bus master and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_raster_display_timing_registers;
  typedef struct packed {
    logic [4:0] idx;
    logic [7:0] wr;
    logic [7:0] rd;
  } rdt_row_type;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic light_pen_strobe = 1'b0;
  rdt_pkg::rdt_bus_type bus;
  rdt_pkg::rdt_timing_type vid;
  logic [7:0] data_out;
  logic data_out_enable;
  logic [7:0] q;
  int n_mismatch = 0;
  int checked = 0;
  int n_hs = 0;
  int n_vs = 0;
  int n_de = 0;
  int n_ra = 0;
  int n_ma = 0;
  logic [7:0] tv [10] = '{8'h09, 8'h04, 8'h06, 8'h02, 8'h07, 8'h00, 8'h05, 8'h01, 8'h00, 8'h02};
  rdt_row_type rows [20] = '{'{5'h00, 8'h3C, 8'h00}, '{5'h01, 8'h28, 8'h00}, '{5'h02, 8'h2D, 8'h00},
    '{5'h03, 8'h0A, 8'h00}, '{5'h04, 8'h1E, 8'h00}, '{5'h05, 8'h02, 8'h00}, '{5'h06, 8'h19, 8'h00},
    '{5'h07, 8'h1B, 8'h00}, '{5'h08, 8'h03, 8'h00}, '{5'h09, 8'h07, 8'h00}, '{5'h0A, 8'h60, 8'h00},
    '{5'h0B, 8'h07, 8'h00}, '{5'h0C, 8'hFF, 8'h00}, '{5'h0D, 8'h5A, 8'h00}, '{5'h0E, 8'hFF, 8'h3F},
    '{5'h0F, 8'hC3, 8'hC3}, '{5'h10, 8'h77, 8'h00}, '{5'h11, 8'h77, 8'h00}, '{5'h12, 8'h55, 8'h00},
    '{5'h1F, 8'hAA, 8'h00}};
  rdt_display_timing DUT (.clk_sys(clk_sys), .arst_n(arst_n), .chip_select_low(bus.cs_n),
    .register_select(bus.rs), .read_not_write(bus.rnw), .bus_enable(bus.e), .data_in(bus.data),
    .data_out(data_out), .data_out_enable(data_out_enable), .light_pen_strobe(light_pen_strobe),
    .vertical_sync(vid.vsync), .horizontal_sync(vid.hsync), .display_window(vid.display),
    .refresh_memory_address(vid.ma), .scan_row_count(vid.ra));
  rdt_host_model host (.clk_sys(clk_sys), .bus(bus), .data_out(data_out), .data_out_enable(data_out_enable));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ------
  // Shared tasks
  // ------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [4:0] idx, input logic [7:0] val);
    logic [7:0] d;
    host.access(1'b1, 1'b0, 1'b0, {3'h0, idx}, d);
    host.access(1'b1, 1'b1, 1'b0, val, d);
  endtask : wr
  task automatic rd(input logic [4:0] idx, output logic [7:0] val);
    logic [7:0] d;
    host.access(1'b1, 1'b0, 1'b0, {3'h0, idx}, d);
    host.access(1'b1, 1'b1, 1'b1, 8'h00, val);
  endtask : rd
  task automatic do_reset;
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("outputs in reset", {data_out_enable, 1'b0, data_out, vid}, 32'h0);
    arst_n = 1'b1;
  endtask : do_reset
  task automatic results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // ------
  // Tests
  // ------
  initial begin
    #200000;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 20; i++) begin
      wr(rows[i].idx, rows[i].wr);
      rd(rows[i].idx, q);
      check("register read", q, rows[i].rd);
    end
    $display("test register map done");
    host.access(1'b1, 1'b0, 1'b1, 8'h00, q);
    check("index read", q, 32'h0);
    host.access(1'b1, 1'b0, 1'b0, 8'h0F, q);
    host.access(1'b0, 1'b1, 1'b0, 8'h11, q);
    host.access(1'b0, 1'b1, 1'b1, 8'h00, q);
    rd(5'h0F, q);
    check("deselected write", q, 32'hC3);
    $display("test index and deselect done");
    do_reset();
    rd(5'h0F, q);
    check("cursor after reset", q, 32'h0);
    wr(5'h0C, 8'hFF);
    wr(5'h0D, 8'h5A);
    repeat (50) @(negedge clk_sys);
    check("refresh address", vid.ma, 32'h3F5A);
    check("display window", vid.display, 32'h0);
    light_pen_strobe = 1'b1;
    repeat (5) @(negedge clk_sys);
    light_pen_strobe = 1'b0;
    repeat (10) @(negedge clk_sys);
    rd(5'h10, q);
    check("light pen high", q, 32'h3F);
    rd(5'h11, q);
    check("light pen low", q, 32'h5A);
    $display("test light pen done");
    for (int i = 0; i < 10; i++) begin
      wr(i[4:0], tv[i]);
    end
    repeat (300) @(negedge clk_sys);
    for (int i = 0; i < 240; i++) begin
      n_hs += vid.hsync;
      n_vs += vid.vsync;
      n_de += vid.display;
      n_ra += (vid.ra == 5'h02);
      n_ma += (vid.ma == 14'h3F5A);
      @(negedge clk_sys);
    end
    check("hsync cycles per frame", n_hs, 32'h30);
    check("vsync cycles per frame", n_vs, 32'hA0);
    check("display cycles per frame", n_de, 32'h3C);
    check("last scan line cycles", n_ra, 32'h50);
    check("start address cycles", n_ma, 32'h3);
    $display("test raster timing done");
    results();
  end
endmodule : test_raster_display_timing_registers
`default_nettype wire
